// [rtl/lpfm_ctrl.sv]
// low-power freeze mode controller: freeze pin, permit qualification, pll gating and idle
//
// Contract
// - pin-only mode: freeze entered 1 us after freeze pin goes low.
// - releasing freeze pin high leaves freeze and resumes normal operation.
// - pin-only mode: pin level and freeze_enable alone decide freeze entry and exit.
// - qualified mode: entry needs pin low and permit high; pin release exits.
// - while frozen, pll-derived clocks are switched off.
// - freeze keeps registers and sram contents with supplies left on and pll clocks gated off.
// - freeze pin glitches are filtered so short pulses cause no transition.
// - idle mode: stopped clocks keep state; restarting clocks resumes operation.
// - pll off input low turns pll off, stops core clock, gives idle.
// - unused freeze pin serves as an ordinary general-purpose input/output.
// - freeze pin value is passed to core logic for state management.
`timescale 1ns/1ps
`default_nettype none
module lpfm_ctrl #(
  parameter int unsigned ENTRY_CYC = lpfm_pkg::ENTRY_DELAY_CYC,
  parameter int unsigned FILTER_CYC = lpfm_pkg::GLITCH_FILTER_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic freeze_enable,
  input wire logic freeze_mode_sel,
  input wire logic freeze_pin_n_i,
  output logic freeze_pin_n_o,
  output logic freeze_pin_n_oe_n,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic gpio_in,
  input wire logic freeze_permit,
  input wire logic pll_off_n,
  output logic freeze_pin_core,
  output logic frozen,
  output logic pll_clk_en,
  output logic idle,
  output logic hold_state
);
  // arming counter only has to reach ENTRY_CYC - 1
  localparam int unsigned EW = $clog2(ENTRY_CYC + 1);

  // synchronised and filtered copies of the asynchronous inputs
  logic pin_sync;
  logic pin_filt;
  logic permit_sync;
  logic pll_filt;
  // state group
  lpfm_pkg::lpfm_state_e state;
  lpfm_pkg::lpfm_state_e next_state;
  logic [EW-1:0] wait_cnt;
  logic [EW-1:0] next_wait_cnt;
  logic entry_ok;
  // next values of the registered outputs
  logic next_frozen;
  logic next_hold_state;
  logic next_pll_clk_en;
  logic next_idle;
  logic next_pin_o;
  logic next_pin_oe_n;
  logic next_gpio_in;
  logic next_pin_core;

  // short pulses die in the filter and never reach the state machine
  lpfm_filter #(.STABLE_CYC(FILTER_CYC), .RST_VAL(lpfm_pkg::PIN_SYNC_RST)) u_pin_filt (
    .sys_clk(sys_clk),
    .srst(srst),
    .raw_in(freeze_pin_n_i),
    .sync_out(pin_sync),
    .filt_out(pin_filt)
  );

  // permit comes from another clock region in user logic, so it is synchronised too
  lpfm_filter #(.STABLE_CYC(1), .RST_VAL(lpfm_pkg::PERMIT_SYNC_RST)) u_permit_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .raw_in(freeze_permit),
    .sync_out(permit_sync),
    .filt_out()
  );

  // pll off request is asynchronous; the one-cycle filter only adds a flop of latency
  lpfm_filter #(.STABLE_CYC(1), .RST_VAL(lpfm_pkg::PLL_SYNC_RST)) u_pll_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .raw_in(pll_off_n),
    .sync_out(),
    .filt_out(pll_filt)
  );

  // pin release, or handing the pin back to gpio, ends arming and freeze alike
  // limitation: freeze_enable low aborts at once, with no filter on it
  function automatic logic exit_wanted(
    input logic enable,
    input logic pin_lvl
  );
    return !enable || pin_lvl;
  endfunction

  // pin-only mode ignores permit entirely, so a stuck permit cannot block entry
  function automatic logic entry_allowed(
    input logic mode_sel,
    input logic pin_lvl,
    input logic permit_lvl
  );
    logic ok;
    ok = !pin_lvl;
    if (mode_sel == lpfm_pkg::MODE_QUALIFIED)
      ok = ok && permit_lvl;
    return ok;
  endfunction

  // state group: run, arming count and frozen
  always_comb
  begin
    entry_ok = entry_allowed(freeze_mode_sel, pin_filt, permit_sync);
    next_state = state;
    next_wait_cnt = '0;
    case (state)
      lpfm_pkg::LPFM_RUN:
      begin
        // freeze_enable comes from logic on this clock and needs no synchroniser
        if (freeze_enable && entry_ok)
          next_state = lpfm_pkg::LPFM_ARMING;
      end
      lpfm_pkg::LPFM_ARMING:
      begin
        // permit dropping here does not abort; only pin release or freeze_enable low does
        if (exit_wanted(freeze_enable, pin_filt))
          next_state = lpfm_pkg::LPFM_RUN;
        else if (wait_cnt == EW'(ENTRY_CYC - 1))
          next_state = lpfm_pkg::LPFM_FROZEN;
        else
          next_wait_cnt = wait_cnt + EW'(1);
      end
      lpfm_pkg::LPFM_FROZEN:
      begin
        // exit is by pin release or freeze_enable low in both modes
        if (exit_wanted(freeze_enable, pin_filt))
          next_state = lpfm_pkg::LPFM_RUN;
      end
      default:
        next_state = lpfm_pkg::LPFM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state <= lpfm_pkg::LPFM_RUN;
      wait_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // mode group: freeze and idle flags, pll gate and the core hold request
  always_comb
  begin
    // taken from next_state so that the flags and the pll gate switch on one edge
    next_frozen = (next_state == lpfm_pkg::LPFM_FROZEN);
    next_idle = !pll_filt;
    next_pll_clk_en = !next_frozen && pll_filt;
    // core registers and sram freeze via hold_state, never reset: state survives
    next_hold_state = next_frozen || next_idle;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      // pll gate resets enabled so the core clock runs straight out of reset
      frozen <= lpfm_pkg::FREEZE_RST;
      idle <= lpfm_pkg::IDLE_RST;
      pll_clk_en <= lpfm_pkg::PLL_EN_RST;
      hold_state <= lpfm_pkg::HOLD_RST;
    end
    else
    begin
      frozen <= next_frozen;
      idle <= next_idle;
      pll_clk_en <= next_pll_clk_en;
      hold_state <= next_hold_state;
    end
  end

  // pin group: gpio use of the freeze pin and the level shown to the core
  always_comb
  begin
    // the pin is only driven as gpio while freeze is disabled, never while it may freeze
    next_pin_o = gpio_out;
    next_pin_oe_n = !(gpio_oe && !freeze_enable);
    // gpio reads the raw synchronised level; only the freeze path needs the filter
    next_gpio_in = pin_sync;
    next_pin_core = pin_filt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      freeze_pin_n_o <= lpfm_pkg::PIN_OUT_RST;
      freeze_pin_n_oe_n <= lpfm_pkg::PIN_OE_N_RST;
      gpio_in <= lpfm_pkg::PIN_SYNC_RST;
      freeze_pin_core <= lpfm_pkg::PIN_SYNC_RST;
    end
    else
    begin
      freeze_pin_n_o <= next_pin_o;
      freeze_pin_n_oe_n <= next_pin_oe_n;
      gpio_in <= next_gpio_in;
      freeze_pin_core <= next_pin_core;
    end
  end
endmodule
`default_nettype wire

// [rtl/lpfm_pkg.sv]
// package: constants for the low-power freeze mode controller
package lpfm_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned ENTRY_DELAY_NS = 1000;
  localparam int unsigned ENTRY_DELAY_CYC = (ENTRY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GLITCH_FILTER_CYC = 4;
  localparam logic MODE_PIN_ONLY = 1'b0;
  localparam logic MODE_QUALIFIED = 1'b1;
  localparam logic FREEZE_RST = 1'b0;
  localparam logic IDLE_RST = 1'b0;
  localparam logic PIN_SYNC_RST = 1'b1;
  localparam logic PLL_EN_RST = 1'b1;
  localparam logic HOLD_RST = 1'b0;
  localparam logic PIN_OUT_RST = 1'b1;
  localparam logic PIN_OE_N_RST = 1'b1;
  localparam logic PERMIT_SYNC_RST = 1'b0;
  localparam logic PLL_SYNC_RST = 1'b1;
  typedef enum logic [1:0] {LPFM_RUN, LPFM_ARMING, LPFM_FROZEN} lpfm_state_e;
endpackage

// [rtl/lpfm_filter.sv]
// two-flop synchroniser followed by a stability glitch filter
`timescale 1ns/1ps
`default_nettype none
module lpfm_filter #(
  parameter int unsigned STABLE_CYC = lpfm_pkg::GLITCH_FILTER_CYC,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic raw_in,
  output logic sync_out,
  output logic filt_out
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  logic meta;
  logic sync;
  logic filt;
  logic [CW-1:0] cnt;
  logic next_filt;
  logic [CW-1:0] next_cnt;

  always_comb
  begin
    next_filt = filt;
    next_cnt = '0;
    if (sync != filt)
    begin
      // level must hold for STABLE_CYC cycles before it is believed
      if (cnt == CW'(STABLE_CYC - 1))
        next_filt = sync;
      else
        next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta <= RST_VAL;
      sync <= RST_VAL;
      filt <= RST_VAL;
      cnt <= '0;
    end
    else
    begin
      meta <= raw_in;
      sync <= meta;
      filt <= next_filt;
      cnt <= next_cnt;
    end
  end

  assign sync_out = sync;
  assign filt_out = filt;
endmodule
`default_nettype wire

// [tb/lpfm_props.sv]
// assertions on the freeze controller ports
`timescale 1ns/1ps
`default_nettype none
module lpfm_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic freeze_enable,
  input wire logic freeze_pin_n_oe_n,
  input wire logic pll_off_n,
  input wire logic freeze_pin_core,
  input wire logic frozen,
  input wire logic pll_clk_en,
  input wire logic idle,
  input wire logic hold_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_rel;
    $rose(freeze_pin_core);
  endsequence
  a_pll_gate: assert property (frozen |-> !pll_clk_en)
    else $error("pll on in freeze");
  a_pll_idle: assert property (idle |-> !pll_clk_en)
    else $error("pll on in idle");
  a_hold_sum: assert property (hold_state == (frozen | idle))
    else $error("hold wrong");
  a_enter_pin: assert property ($rose(frozen) |-> !freeze_pin_core)
    else $error("entry without pin");
  a_exit_pin: assert property (s_rel |-> ##[0:2] !frozen)
    else $error("no exit");
  a_gpio_oe: assert property (freeze_enable |=> freeze_pin_n_oe_n)
    else $error("pin driven");
  a_gpio_frz: assert property (!freeze_enable |=> !frozen)
    else $error("freeze as gpio");
  a_idle_on: assert property (!pll_off_n [*6] |-> idle)
    else $error("no idle");
endmodule
bind lpfm_ctrl lpfm_props props_u (
  .sys_clk(sys_clk),
  .srst(srst),
  .freeze_enable(freeze_enable),
  .freeze_pin_n_oe_n(freeze_pin_n_oe_n),
  .pll_off_n(pll_off_n),
  .freeze_pin_core(freeze_pin_core),
  .frozen(frozen),
  .pll_clk_en(pll_clk_en),
  .idle(idle),
  .hold_state(hold_state)
);
`default_nettype wire

// [tb/lpfm_host.sv]
// far side: drives the freeze pin and the permit
`timescale 1ns/1ps
`default_nettype none
module lpfm_host (
  input wire logic sys_clk,
  input wire logic req,
  input wire logic perm_ok,
  output logic pin_n,
  output logic permit
);
  // moves on the rising edge by non-blocking assignment, so it never races the bench
  always @(posedge sys_clk)
  begin
    pin_n <= !req;
    // permit follows pin low one cycle late, so it drops one cycle after the pin is released
    permit <= perm_ok && !pin_n;
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the freeze controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic fen = 1'b1, msel = 1'b0, go = 1'b0, pok = 1'b0, goe = 1'b0, gout = 1'b0, poff_n = 1'b1;
  logic pin_n, pin_o, oe_n, permit, gin, core, frozen, pll_en, idle, hold, pin_w;
  int fail_count = 0, n_tests = 0, seed;
  always #4 sys_clk = ~sys_clk;
  assign pin_w = oe_n ? pin_n : pin_o;
  lpfm_host host_u (.sys_clk(sys_clk), .req(go), .perm_ok(pok), .pin_n(pin_n), .permit(permit));
  lpfm_ctrl #(.ENTRY_CYC(8), .FILTER_CYC(2)) dut_u (.sys_clk(sys_clk), .srst(srst), .freeze_enable(fen),
    .freeze_mode_sel(msel), .freeze_pin_n_i(pin_w), .freeze_pin_n_o(pin_o), .freeze_pin_n_oe_n(oe_n),
    .gpio_out(gout), .gpio_oe(goe), .gpio_in(gin), .freeze_permit(permit), .pll_off_n(poff_n),
    .freeze_pin_core(core), .frozen(frozen), .pll_clk_en(pll_en), .idle(idle), .hold_state(hold));
  task automatic tally_and_finish;
    $display("checks %0d bad %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_frz(input logic v);
    for (int i = 0; i < 30 && frozen !== v; i++)
      cyc(1);
    chk("frozen", v, frozen);
    if (frozen !== v)
      tally_and_finish();
  endtask
  initial
  begin
    seed = $urandom(89686);
    cyc(4);
    srst = 1'b0;
    chk("oe_n", 1'b1, oe_n);
    repeat (6)
    begin
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      repeat (6 + $urandom % 4)
      begin
        cyc(1);
        chk("core", 1'b1, core);
      end
    end
    go = 1'b1;
    cyc(10);
    chk("frozen", 1'b0, frozen);
    wait_frz(1'b1);
    chk("core", 1'b0, core);
    chk("pll_en", 1'b0, pll_en);
    chk("hold", 1'b1, hold);
    cyc(20);
    chk("frozen", 1'b1, frozen);
    srst = 1'b1;
    cyc(2);
    chk("frozen", 1'b0, frozen);
    chk("pll_en", 1'b1, pll_en);
    chk("hold", 1'b0, hold);
    chk("core", 1'b1, core);
    srst = 1'b0;
    wait_frz(1'b1);
    go = 1'b0;
    wait_frz(1'b0);
    msel = 1'b1;
    go = 1'b1;
    cyc(30);
    chk("frozen", 1'b0, frozen);
    pok = 1'b1;
    wait_frz(1'b1);
    go = 1'b0;
    wait_frz(1'b0);
    poff_n = 1'b0;
    cyc(8);
    chk("idle", 1'b1, idle);
    chk("pll_en", 1'b0, pll_en);
    chk("hold", 1'b1, hold);
    poff_n = 1'b1;
    cyc(8);
    chk("idle", 1'b0, idle);
    chk("pll_en", 1'b1, pll_en);
    fen = 1'b0;
    goe = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      // first two values are fixed so that both levels are always seen
      gout = (k < 2) ? 1'(k) : 1'($urandom);
      cyc(30);
      chk("gpio_in", gout, gin);
      chk("oe_n", 1'b0, oe_n);
      chk("frozen", 1'b0, frozen);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
